// file: hw/lbgs_regs.svh
// Purpose: Constants for the LED buck gate sequencer.
// Assumes: 10 MHz clock, 100 ns period.
// Notes: Time figures are turned into clock counts inside the design.
// Function
// - Either current comparator trip turns gate off.
// - Off timer starts when gate drops.
// - Timer expiry turns gate back on.
// - Ignore peak trip comparators 500 ns after turn-on.
// - Off time is programmable count, 40ps/ohm.
// - Dimming below 0.5V keeps gate off.
// - Threshold tenth of dimming, capped 0.25V.
// - Floating dimming input uses full threshold.
// - Overcurrent holds gate low for 4 ms.
// - Off over 4 s restarts at 100%.
// - Short mains cycle advances current level.
// - Straps select level sequence.
// - After last level, wrap to 100%.
// - Both straps floating: always 100%.
// - Dimming low stops only switching.
`ifndef LBGS_REGS_SVH
`define LBGS_REGS_SVH
`define LBGS_CLK_PERIOD_NS 100
`define LBGS_BLANK_NS 500
`define LBGS_OCP_HOLD_MS 4
`define LBGS_SEQ_WINDOW_S 4
`define LBGS_TOFF_PS_PER_OHM 40
`define LBGS_PCT_FULL 7'h64
`define LBGS_PCT_30 7'h1E
`define LBGS_PCT_50 7'h32
`define LBGS_PCT_20 7'h14
`define LBGS_INT_LEVEL_EV 0
`define LBGS_INT_OCP_EV 1
`define LBGS_NS_PER_MS 1000000
`define LBGS_MS_PER_S 1000
`define LBGS_A_STAT 4'h0
`define LBGS_A_MASK 4'h4
`define LBGS_A_STATE 4'h8
`endif

// file: hw/lbgs_pkg.sv
// Purpose: Types for the LED buck gate sequencer.
// Assumes: Used by lbgs_top and its bench.
// Notes: Comparator results travel together as one struct.
`default_nettype none
package lbgs_pkg;
	// Switching phase of the gate controller.
	typedef enum logic [1:0] {LBGS_ON, LBGS_OFF, LBGS_HOLD, LBGS_DIM} lbgs_phase_t;
	// Sequence selected by the straps.
	typedef enum logic [1:0] {LBGS_SEQ_NONE, LBGS_SEQ_30, LBGS_SEQ_50, LBGS_SEQ_50_20} lbgs_seq_t;
	// Analog comparator results, all active high.
	typedef struct packed {
		logic fixed_trip;  // Sense above the fixed 250 mV reference.
		logic dim_trip;    // Sense above one tenth of the dimming input.
		logic ocp_trip;    // Sense above the 0.4 V overcurrent limit.
		logic dim_low;     // Dimming input below 0.5 V.
	} lbgs_cmp_t;
endpackage
`default_nettype wire

// file: hw/lbgs_top.sv
// Purpose: Gate sequencing for a constant off-time peak current LED buck driver.
// Assumes: Comparators and the threshold DAC are analog; they arrive as asynchronous levels.
// Notes: The threshold output is a percentage fed to the analog reference scaler.
//
// Decided for this implementation: the plain strobed port and the address map.
`include "lbgs_regs.svh"
`default_nettype none
module lbgs_top
	import lbgs_pkg::*;
#(
	parameter int TOFF_W = 24,
	parameter int OCP_HOLD_CYC = (`LBGS_OCP_HOLD_MS * `LBGS_NS_PER_MS) / `LBGS_CLK_PERIOD_NS,
	parameter int SEQ_WIN_CYC =
		(`LBGS_SEQ_WINDOW_S * `LBGS_NS_PER_MS) / `LBGS_CLK_PERIOD_NS * `LBGS_MS_PER_S
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Asynchronous analog comparator results and pins.
	input wire lbgs_cmp_t cmp_i,
	input wire logic dim_float_i,
	input wire logic seq_cfg_a_gnd_i,
	input wire logic seq_cfg_b_gnd_i,
	input wire logic mains_ok_i,
	// Programmed off time in clock cycles (timing resistor times 40 ps / period).
	input wire logic [TOFF_W-1:0] toff_cyc_i,
	// Plain register port.
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Gate drive, level percentage and interrupt.
	output logic gate_o,
	output logic [6:0] level_pct_o,
	output logic blank_o,
	output logic irq_o
);
	// ----------------------------------------------------------------
	// Constants
	// ----------------------------------------------------------------
	// Blanking count rounds up to whole cycles.
	localparam int BLANK_CYC = (`LBGS_BLANK_NS + `LBGS_CLK_PERIOD_NS - 1) / `LBGS_CLK_PERIOD_NS;
	localparam logic [3:0] BLANK_MAX = 4'(BLANK_CYC - 1);
	localparam logic [3:0] A_STAT = `LBGS_A_STAT;
	localparam logic [3:0] A_MASK = `LBGS_A_MASK;
	localparam logic [3:0] A_STATE = `LBGS_A_STATE;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Three stages; a change counts once stages two and three agree.
	localparam int NS = 8;
	logic [NS-1:0] raw_in;
	logic [NS-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
	assign raw_in = {cmp_i, dim_float_i, seq_cfg_a_gnd_i, seq_cfg_b_gnd_i, mains_ok_i};
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			// Each input has its own three-stage chain and filter.
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_ff[gi] <= 1'b0;
					s2_ff[gi] <= 1'b0;
					s3_ff[gi] <= 1'b0;
					clean_ff[gi] <= 1'b0;
				end else begin
					s1_ff[gi] <= raw_in[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi]) begin
						clean_ff[gi] <= s3_ff[gi];
					end
				end
			end
		end
	endgenerate
	lbgs_cmp_t cmp_s;
	logic dim_float_s, cfg_a_s, cfg_b_s, mains_s;
	assign {cmp_s, dim_float_s, cfg_a_s, cfg_b_s, mains_s} = clean_ff;

	// Floating dimming input is pulled high: full threshold, no PWM dimming.
	logic dim_off;
	assign dim_off = cmp_s.dim_low && !dim_float_s;
	// Either comparator ends the on phase; dim trip ignored when floating.
	logic peak_trip;
	assign peak_trip = cmp_s.fixed_trip || (cmp_s.dim_trip && !dim_float_s);

	// ----------------------------------------------------------------
	// Gate state machine
	// ----------------------------------------------------------------
	lbgs_phase_t phase_ff;
	lbgs_phase_t nxt_phase;
	logic [3:0] blank_ff;
	logic [TOFF_W-1:0] toff_ff;
	logic [31:0] hold_ff;
	logic in_blank;
	assign in_blank = (blank_ff != 4'h0);

	// Next phase; dimming wins except during the overcurrent hold, then overcurrent, then normal switching.
	always_comb begin
		nxt_phase = phase_ff;
		case (phase_ff)
			LBGS_ON: begin
				if (dim_off) begin
					nxt_phase = LBGS_DIM;
				end else if (cmp_s.ocp_trip) begin
					nxt_phase = LBGS_HOLD;
				end else if (peak_trip && !in_blank) begin
					nxt_phase = LBGS_OFF;
				end
			end
			LBGS_OFF: begin
				if (dim_off) begin
					nxt_phase = LBGS_DIM;
				end else if (toff_ff <= TOFF_W'(1)) begin
					nxt_phase = LBGS_ON;
				end
			end
			LBGS_HOLD: begin
				if (hold_ff <= 32'h1) begin
					nxt_phase = dim_off ? LBGS_DIM : LBGS_ON;
				end
			end
			LBGS_DIM: begin
				if (!dim_off) begin
					nxt_phase = LBGS_ON;
				end
			end
			default: nxt_phase = LBGS_DIM;
		endcase
	end

	// Phase register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_ff <= LBGS_DIM;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	// Blanking counter loaded on every entry to the on phase.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blank_ff <= 4'h0;
		end else if (nxt_phase == LBGS_ON && phase_ff != LBGS_ON) begin
			blank_ff <= BLANK_MAX + 4'h1;
		end else if (blank_ff != 4'h0) begin
			blank_ff <= blank_ff - 4'h1;
		end
	end

	// Off timer starts as the gate falls after a peak trip.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			toff_ff <= '0;
		end else if (phase_ff == LBGS_ON && nxt_phase == LBGS_OFF) begin
			toff_ff <= toff_cyc_i;
		end else if (phase_ff == LBGS_OFF && toff_ff != '0) begin
			toff_ff <= toff_ff - TOFF_W'(1);
		end
	end

	// Overcurrent hold counter; no off-timer restarts while it runs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_ff <= 32'h0;
		end else if (phase_ff != LBGS_HOLD && nxt_phase == LBGS_HOLD) begin
			hold_ff <= 32'(OCP_HOLD_CYC);
		end else if (phase_ff == LBGS_HOLD && hold_ff != 32'h0) begin
			hold_ff <= hold_ff - 32'h1;
		end
	end

	// Registered gate and blanking outputs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_o <= 1'b0;
			blank_o <= 1'b0;
		end else begin
			gate_o <= (nxt_phase == LBGS_ON);
			blank_o <= (nxt_phase == LBGS_ON) && (phase_ff != LBGS_ON || blank_ff > 4'h1);
		end
	end

	// ----------------------------------------------------------------
	// Power level sequencer
	// ----------------------------------------------------------------
	lbgs_seq_t seq_sel;
	// Strap decode: a grounded strap reads as one.
	always_comb begin
		case ({cfg_a_s, cfg_b_s})
			2'b01: seq_sel = LBGS_SEQ_30;
			2'b10: seq_sel = LBGS_SEQ_50;
			2'b11: seq_sel = LBGS_SEQ_50_20;
			default: seq_sel = LBGS_SEQ_NONE;
		endcase
	end

	logic [1:0] step_ff;
	logic [31:0] dark_ff;
	logic mains_d_ff;
	logic rise;
	assign rise = mains_s && !mains_d_ff;
	// A rise counts as a sequencing action only after a short dark time.
	logic short_rise;
	assign short_rise = rise && (dark_ff <= 32'(SEQ_WIN_CYC));
	logic [1:0] last_step;
	assign last_step = (seq_sel == LBGS_SEQ_50_20) ? 2'h2 : 2'h1;

	// Mains edge tracking and dark-time measurement, kept on hold-up supply.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mains_d_ff <= 1'b0;
			// Reset counts as a long power-off, so the first rise starts at full level.
			dark_ff <= 32'(SEQ_WIN_CYC + 1);
		end else begin
			mains_d_ff <= mains_s;
			if (mains_s) begin
				dark_ff <= 32'h0;
			end else if (dark_ff <= 32'(SEQ_WIN_CYC)) begin
				dark_ff <= dark_ff + 32'h1;
			end
		end
	end

	// Level step: advance on a short cycle, back to full after a long one.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step_ff <= 2'h0;
		end else if (seq_sel == LBGS_SEQ_NONE) begin
			step_ff <= 2'h0;
		end else if (dark_ff > 32'(SEQ_WIN_CYC)) begin
			// Long dark time; this also covers the rise cycle that ends it.
			step_ff <= 2'h0;
		end else if (short_rise) begin
			step_ff <= (step_ff >= last_step) ? 2'h0 : step_ff + 2'h1;
		end
	end

	// Percentage to the reference scaler.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_pct_o <= `LBGS_PCT_FULL;
		end else begin
			case (step_ff)
				2'h1: level_pct_o <= (seq_sel == LBGS_SEQ_30) ? `LBGS_PCT_30 : `LBGS_PCT_50;
				2'h2: level_pct_o <= `LBGS_PCT_20;
				default: level_pct_o <= `LBGS_PCT_FULL;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupts and register port
	// ----------------------------------------------------------------
	logic [1:0] stat_ff, mask_ff;
	logic [1:0] ev;
	assign ev[`LBGS_INT_LEVEL_EV] = short_rise && seq_sel != LBGS_SEQ_NONE;
	assign ev[`LBGS_INT_OCP_EV] = (phase_ff != LBGS_HOLD) && (nxt_phase == LBGS_HOLD);

	// Sticky status; a new event wins over a write-one clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_ff <= 2'h0;
		end else if (wr_i && addr_i == A_STAT) begin
			stat_ff <= (stat_ff & ~wdata_i[1:0]) | ev;
		end else begin
			stat_ff <= stat_ff | ev;
		end
	end

	// Mask register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_ff <= 2'h0;
		end else if (wr_i && addr_i == A_MASK) begin
			mask_ff <= wdata_i[1:0];
		end
	end

	assign irq_o = |(stat_ff & mask_ff);

	// Read data valid the cycle after the strobe, zero otherwise.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0;
		end else if (rd_i && addr_i == A_STAT) begin
			rdata_o <= {30'h0, stat_ff};
		end else if (rd_i && addr_i == A_MASK) begin
			rdata_o <= {30'h0, mask_ff};
		end else if (rd_i && addr_i == A_STATE) begin
			rdata_o <= {21'h0, level_pct_o, step_ff, phase_ff};
		end else begin
			rdata_o <= 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_trip_off;
		@(posedge clk_i) disable iff (rst_i)
		(phase_ff == LBGS_ON && peak_trip && !in_blank && !dim_off && !cmp_s.ocp_trip)
			|=> !gate_o;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("gate not off after trip");

	property p_timer_start;
		@(posedge clk_i) disable iff (rst_i)
		(phase_ff == LBGS_ON && nxt_phase == LBGS_OFF) |=> (toff_ff == $past(toff_cyc_i));
	endproperty
	a_timer_start: assert property (p_timer_start) else $error("off timer not loaded");

	property p_expire_on;
		@(posedge clk_i) disable iff (rst_i)
		(phase_ff == LBGS_OFF && toff_ff == TOFF_W'(1) && !dim_off) |=> gate_o;
	endproperty
	a_expire_on: assert property (p_expire_on) else $error("gate not on after off time");

	property p_blank;
		@(posedge clk_i) disable iff (rst_i)
		(phase_ff != LBGS_ON && nxt_phase == LBGS_ON) |=> (phase_ff != LBGS_OFF) [*5];
	endproperty
	a_blank: assert property (p_blank) else $error("on phase cut during blanking");

	property p_dim_off;
		@(posedge clk_i) disable iff (rst_i)
		dim_off |=> !gate_o;
	endproperty
	a_dim_off: assert property (p_dim_off) else $error("gate on while dimmed off");

	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		(phase_ff != LBGS_HOLD && nxt_phase == LBGS_HOLD) |=> !gate_o [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("gate on during overcurrent hold");

	property p_long_off;
		@(posedge clk_i) disable iff (rst_i)
		(!mains_s && dark_ff > 32'(SEQ_WIN_CYC) && seq_sel != LBGS_SEQ_NONE) |=> step_ff == 2'h0;
	endproperty
	a_long_off: assert property (p_long_off) else $error("level kept after long off");

	property p_advance;
		@(posedge clk_i) disable iff (rst_i)
		(rise && seq_sel != LBGS_SEQ_NONE && dark_ff <= 32'(SEQ_WIN_CYC) && step_ff < last_step)
			|=> step_ff == $past(step_ff) + 2'h1;
	endproperty
	a_advance: assert property (p_advance) else $error("level did not advance");

	property p_wrap;
		@(posedge clk_i) disable iff (rst_i)
		(rise && seq_sel != LBGS_SEQ_NONE && step_ff >= last_step) |=> step_ff == 2'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("level did not wrap");

	property p_no_seq;
		@(posedge clk_i) disable iff (rst_i)
		(seq_sel == LBGS_SEQ_NONE) |=> ##1 level_pct_o == `LBGS_PCT_FULL || seq_sel != LBGS_SEQ_NONE;
	endproperty
	a_no_seq: assert property (p_no_seq) else $error("not full with no sequence");

	property p_hold_exit;
		@(posedge clk_i) disable iff (rst_i)
		(phase_ff == LBGS_HOLD && nxt_phase == LBGS_ON) |=> (gate_o && blank_o);
	endproperty
	a_hold_exit: assert property (p_hold_exit) else $error("hold exit unblanked");

	property p_ocp_event;
		@(posedge clk_i) disable iff (rst_i)
		(phase_ff != LBGS_HOLD && nxt_phase == LBGS_HOLD) |=> stat_ff[`LBGS_INT_OCP_EV];
	endproperty
	a_ocp_event: assert property (p_ocp_event) else $error("no overcurrent event");

	property p_long_rise;
		@(posedge clk_i) disable iff (rst_i)
		(rise && dark_ff > 32'(SEQ_WIN_CYC)) |=> step_ff == 2'h0;
	endproperty
	a_long_rise: assert property (p_long_rise) else $error("long cycle advanced");

	property p_level_30;
		@(posedge clk_i) disable iff (rst_i)
		(seq_sel == LBGS_SEQ_30 && step_ff == 2'h1) |=> level_pct_o == `LBGS_PCT_30;
	endproperty
	a_level_30: assert property (p_level_30) else $error("wrong second level");
endmodule // lbgs_top
`default_nettype wire

// file: testbench/lbgs_partner.sv
// Purpose: Switch, inductor and sense resistor model for the gate sequencer bench.
// Assumes: Sense current ramps while the gate is high and is zero while it is low.
// Notes: A one-cycle turn-on spike precedes the ramp.
`default_nettype none
module lbgs_partner #(
	parameter int RAMP = 12
) (
	// Clock and switch drive.
	input wire logic clk_i,
	input wire logic gate_i,
	// Shorted output command from the bench.
	input wire logic short_i,
	// Comparator results.
	output logic fixed_trip_o,
	output logic ocp_trip_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int on_cnt; // Cycles since the switch closed.
	// The count restarts each time the switch opens.
	always_ff @(posedge clk_i) begin
		if (gate_i) begin
			on_cnt <= on_cnt + 1;
		end else begin
			on_cnt <= 0;
		end
	end
	// Spike in the first on cycle, then the ramp crosses the reference.
	assign fixed_trip_o = gate_i && (on_cnt == 0 || on_cnt >= RAMP);
	// A shorted output overshoots the overcurrent limit late in the ramp.
	assign ocp_trip_o = gate_i && short_i && on_cnt >= RAMP - 2;
endmodule // lbgs_partner
`default_nettype wire

// file: testbench/tb_lbgs_top.sv
// Purpose: Self-checking bench for the gate sequencer.
// Assumes: Short hold and window parameters keep the run brief.
// Notes: Counts are taken one nanosecond after each rising edge.
`include "lbgs_regs.svh"
`default_nettype none
module tb_lbgs_top;
	timeunit 1ns;
	timeprecision 1ns;
	import lbgs_pkg::*;
	localparam int HOLD = 20; // Shortened overcurrent hold.
	localparam int WIN = 50; // Shortened sequencing window.
	localparam int RAMP = 12; // Partner ramp length.
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic dim_trip = 1'b0;
	logic dim_low = 1'b0;
	logic short_cmd = 1'b0;
	logic fixed_trip;
	logic ocp_trip;
	lbgs_cmp_t cmp;
	logic dim_float = 1'b1;
	logic cfg_a = 1'b0;
	logic cfg_b = 1'b0;
	logic mains = 1'b1;
	logic [23:0] toff = 24'h000008;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic gate;
	logic [6:0] level;
	logic blank;
	logic irq;
	int miscompares = 0;
	int samples_checked = 0;
	assign cmp = '{fixed_trip: fixed_trip, dim_trip: dim_trip, ocp_trip: ocp_trip,
		dim_low: dim_low};
	// Clock generator, 100 ns period.
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	lbgs_top #(.OCP_HOLD_CYC(HOLD), .SEQ_WIN_CYC(WIN)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.cmp_i(cmp), .dim_float_i(dim_float), .seq_cfg_a_gnd_i(cfg_a),
		.seq_cfg_b_gnd_i(cfg_b), .mains_ok_i(mains), .toff_cyc_i(toff), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .gate_o(gate),
		.level_pct_o(level), .blank_o(blank), .irq_o(irq));
	lbgs_partner #(.RAMP(RAMP)) i_sense (.clk_i(clk_i), .gate_i(gate), .short_i(short_cmd),
		.fixed_trip_o(fixed_trip), .ocp_trip_o(ocp_trip));
	// Compares a value and counts the result.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Compares a bench count against a range.
	task automatic chk_rng(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("unexpected at %0t: count %h range %h to %h", $time, got, lo, hi);
		end
	endtask
	// Lets n edges pass and settles.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Counts cycles until the gate shows the level, bounded by lim.
	task automatic wait_gate(input logic lvl, input int lim, output int n);
		n = 0;
		while (gate !== lvl && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	// One-cycle register write.
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
		#1;
	endtask
	// One-cycle register read; data stand in the following cycle.
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Outputs right after reset, and an unmapped address.
	task automatic t_reset();
		logic [31:0] d;
		chk(gate, 1'b0);
		chk(level, `LBGS_PCT_FULL);
		chk(irq, 1'b0);
		reg_wr(4'hC, 32'hFFFFFFFF);
		reg_rd(4'hC, d);
		chk(d, 32'h0);
		$display("test reset done");
	endtask
	// Off time equals the count, blanking hides the spike.
	task automatic t_switch(input logic [23:0] t);
		int n;
		int b;
		int off;
		@(posedge clk_i);
		toff <= t;
		wait_gate(0, 200, n);
		wait_gate(1, 200, n);
		wait_gate(0, 200, n);
		wait_gate(1, 200, n);
		b = 0;
		while (blank === 1'b1 && b < 20) begin
			tick(1);
			b++;
		end
		chk_rng(b, 5, 5);
		wait_gate(0, 200, n);
		chk_rng(n + b, RAMP, RAMP + 12);
		wait_gate(1, 200, off);
		chk(32'(off), 32'(t));
		$display("test switch done");
	endtask
	// Measures one on phase.
	task automatic on_time(output int n);
		wait_gate(0, 200, n);
		wait_gate(1, 200, n);
		wait_gate(0, 200, n);
	endtask
	// Dimming comparator ends the phase unless the input floats.
	task automatic t_dimtrip();
		int n;
		@(posedge clk_i);
		dim_float <= 1'b0;
		dim_trip <= 1'b1;
		on_time(n);
		on_time(n);
		chk_rng(n, 5, 9);
		@(posedge clk_i);
		dim_float <= 1'b1;
		on_time(n);
		on_time(n);
		chk_rng(n, RAMP, RAMP + 12);
		@(posedge clk_i);
		dim_trip <= 1'b0;
		$display("test dim trip done");
	endtask
	// Low dimming input stops switching only.
	task automatic t_dimlow();
		int n;
		int hi;
		logic [31:0] d;
		@(posedge clk_i);
		dim_float <= 1'b0; // A driven input, so its low level counts.
		dim_low <= 1'b1;
		tick(10);
		hi = 0;
		repeat (40) begin
			tick(1);
			hi += (gate !== 1'b0);
		end
		chk_rng(hi, 0, 0);
		chk(level, `LBGS_PCT_FULL);
		reg_rd(`LBGS_A_STATE, d);
		chk(d, 32'h00000643);
		@(posedge clk_i);
		dim_low <= 1'b0;
		wait_gate(1, 30, n);
		chk_rng(n, 1, 12);
		chk(blank, 1'b1);
		@(posedge clk_i);
		dim_float <= 1'b1;
		$display("test dim low done");
	endtask
	// Overcurrent hold, its event bit and the interrupt.
	task automatic t_ocp();
		int n;
		logic [31:0] d;
		@(posedge clk_i);
		short_cmd <= 1'b1;
		wait_gate(1, 200, n);
		wait_gate(0, 200, n);
		@(posedge clk_i);
		short_cmd <= 1'b0;
		#1;
		wait_gate(1, 200, n);
		chk_rng(n + 1, HOLD, HOLD + 3);
		chk(blank, 1'b1);
		reg_rd(4'h0, d);
		chk(d & 32'h2, 32'h2);
		chk(irq, 1'b0);
		reg_wr(4'h4, 32'h3);
		chk(irq, 1'b1);
		reg_wr(4'h0, 32'h2);
		chk(irq, 1'b0);
		$display("test overcurrent done");
	endtask
	// One mains interruption of the given length.
	task automatic mains_cycle(input int dark);
		@(posedge clk_i);
		mains <= 1'b0;
		repeat (dark) @(posedge clk_i);
		mains <= 1'b1;
		tick(12);
	endtask
	// Level sequence for one strap setting.
	task automatic t_seq(input logic a, input logic b, input logic [6:0] l1,
		input logic [6:0] l2, input logic [6:0] l3);
		logic [31:0] d;
		@(posedge clk_i);
		cfg_a <= a;
		cfg_b <= b;
		mains_cycle(WIN + 30);
		chk(level, `LBGS_PCT_FULL);
		reg_wr(4'h0, 32'h3);
		mains_cycle(10);
		chk(level, l1);
		mains_cycle(10);
		chk(level, l2);
		mains_cycle(10);
		chk(level, l3);
		reg_rd(4'h0, d);
		chk(d & 32'h1, 32'(l1 != `LBGS_PCT_FULL));
		chk(irq, l1 != `LBGS_PCT_FULL);
		mains_cycle(WIN + 30);
		chk(level, `LBGS_PCT_FULL);
		$display("test sequence done");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("compares %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hang.
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		test_done();
	end
	// Main sequence.
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		t_reset();
		t_switch(24'h000008);
		t_switch(24'h000003);
		t_dimtrip();
		t_dimlow();
		t_ocp();
		t_seq(1'b0, 1'b0, `LBGS_PCT_FULL, `LBGS_PCT_FULL, `LBGS_PCT_FULL);
		t_seq(1'b0, 1'b1, `LBGS_PCT_30, `LBGS_PCT_FULL, `LBGS_PCT_30);
		t_seq(1'b1, 1'b0, `LBGS_PCT_50, `LBGS_PCT_FULL, `LBGS_PCT_50);
		t_seq(1'b1, 1'b1, `LBGS_PCT_50, `LBGS_PCT_20, `LBGS_PCT_FULL);
		test_done();
	end
endmodule // tb_lbgs_top
`default_nettype wire
